// File: bus_party.sv
// Far-side bus party that drives one data side while the block leaves it as input.
`timescale 1ns/1ns
module bus_party (
  // Clock.
  input wire logic clk,
  // Far-side drive request.
  input wire logic drive_en,
  input wire logic [17:0] drive_val,
  // Block pin halves.
  input wire logic [17:0] pin_out,
  input wire logic pin_oe,
  // Resolved wire level.
  output logic [17:0] level
);
  logic [17:0] last_r;
  // An undriven line shows the inverse of its last value, so stale data never passes for new data.
  always_comb level = pin_oe ? pin_out : (drive_en ? drive_val : ~last_r);
  always_ff @(posedge clk) last_r <= level;
endmodule : bus_party

// File: dual_direction_fifo_transceiver.sv
// One-direction strobed FIFO and the two-port transceiver top built from two of them.
`timescale 1ns/1ns
`include "dual_fifo_consts.svh"

module strobed_fifo #(
  parameter int DEPTH = `FIFO_DEPTH,
  parameter int WIDTH = `FIFO_WIDTH,
  parameter int HALF_LEVEL = `FIFO_HALF_LEVEL,
  parameter int OFS_W = `OFFSET_BITS
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // FIFO controls.
  input wire logic clear_n,
  input wire logic write_strobe,
  input wire logic read_strobe,
  input wire logic offset_prog_n,
  // Data.
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout,
  output dual_fifo_pkg::fifo_flags_t flags
);

  localparam int AW = $clog2(DEPTH);
  // The count is one bit wider than the pointers so that a full FIFO differs from an empty one.
  localparam int CW = AW + 1;
  localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);
  localparam logic [CW-1:0] HALF_COUNT = CW'(HALF_LEVEL);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [WIDTH-1:0] mem_nxt [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] wr_ptr_nxt;
  logic [AW-1:0] rd_ptr_r;
  logic [AW-1:0] rd_ptr_nxt;
  logic [CW-1:0] count_r;
  logic [CW-1:0] count_nxt;
  logic [WIDTH-1:0] dout_r;
  logic [WIDTH-1:0] dout_nxt;
  logic [OFS_W-1:0] empty_ofs_r;
  logic [OFS_W-1:0] empty_ofs_nxt;
  logic [OFS_W-1:0] full_ofs_r;
  logic [OFS_W-1:0] full_ofs_nxt;
  dual_fifo_pkg::prog_state_t prog_r;
  dual_fifo_pkg::prog_state_t prog_nxt;
  dual_fifo_pkg::fifo_flags_t flags_r;
  dual_fifo_pkg::fifo_flags_t flags_nxt;
  logic wr_prev_r;
  logic rd_prev_r;
  logic wr_prev_nxt;
  logic rd_prev_nxt;
  logic wr_edge;
  logic rd_edge;
  logic prog_edge;
  logic do_write;
  logic do_read;
  logic [AW-1:0] rd_ptr_inc;

  // --------------------------------------------------------------------------
  // Strobe edges
  // --------------------------------------------------------------------------
  // Write and read strobes are watched separately, so the fill and drain
  // rates never constrain each other.
  // A strobe must be sampled low between two actions; a faster toggle is lost.
  // Program edges are only taken before the first data write after a clear.
  assign wr_edge = write_strobe & ~wr_prev_r; // [R3] [R17]
  assign rd_edge = read_strobe & ~rd_prev_r; // [R3] [R18]
  assign prog_edge = wr_edge & ~offset_prog_n & (prog_r != dual_fifo_pkg::PROG_DONE); // [R20]
  assign do_write = wr_edge & ~prog_edge & (count_r != FULL_COUNT); // [R17] [R21]
  assign do_read = rd_edge & (count_r != '0); // [R18] [R21]
  assign rd_ptr_inc = rd_ptr_r + AW'(1);

  always_comb begin
    wr_prev_nxt = write_strobe;
    rd_prev_nxt = read_strobe;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_prev_r <= 1'b0;
      rd_prev_r <= 1'b0;
    end else begin
      wr_prev_r <= wr_prev_nxt;
      rd_prev_r <= rd_prev_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // Next state of storage, pointers, offsets and flags
  // --------------------------------------------------------------------------
  always_comb begin
    mem_nxt = mem_r;
    wr_ptr_nxt = wr_ptr_r;
    rd_ptr_nxt = rd_ptr_r;
    count_nxt = count_r;
    dout_nxt = dout_r;
    empty_ofs_nxt = empty_ofs_r;
    full_ofs_nxt = full_ofs_r;
    prog_nxt = prog_r;
    // Clear is taken on the clock edge, so a clear pulse shorter than one period can be missed.
    if (!clear_n) begin
      wr_ptr_nxt = '0; // [R19]
      rd_ptr_nxt = '0;
      count_nxt = '0;
      dout_nxt = '0;
      empty_ofs_nxt = `OFFSET_DEFAULT; // [R9]
      full_ofs_nxt = `OFFSET_DEFAULT; // [R9]
      prog_nxt = dual_fifo_pkg::PROG_FIRST;
    end else begin
      // Offset programming stores no data word.
      if (prog_edge) begin
        case (prog_r)
          dual_fifo_pkg::PROG_FIRST: begin
            empty_ofs_nxt = din[OFS_W-1:0]; // [R20]
            full_ofs_nxt = din[OFS_W-1:0]; // [R20]
            prog_nxt = dual_fifo_pkg::PROG_SECOND;
          end
          dual_fifo_pkg::PROG_SECOND: begin
            full_ofs_nxt = din[OFS_W-1:0]; // [R20]
            prog_nxt = dual_fifo_pkg::PROG_DONE;
          end
          default: begin
            prog_nxt = dual_fifo_pkg::PROG_DONE;
          end
        endcase
      end
      // Once data is written the offsets are frozen until the next clear.
      if (do_write) begin
        mem_nxt[wr_ptr_r] = din; // [R17]
        wr_ptr_nxt = wr_ptr_r + AW'(1);
        prog_nxt = dual_fifo_pkg::PROG_DONE;
      end
      if (do_read) begin
        rd_ptr_nxt = rd_ptr_inc; // [R18]
      end
      case ({do_write, do_read})
        2'b10: count_nxt = count_r + CW'(1);
        2'b01: count_nxt = count_r - CW'(1);
        default: count_nxt = count_r;
      endcase
      // The head word is held in a register so the output lines always show
      // the oldest word; a word written into an empty FIFO goes straight there.
      if (do_write && count_r == '0) begin
        dout_nxt = din; // [R17]
      end else if (do_read && count_r == CW'(1) && do_write) begin
        dout_nxt = din; // [R17]
      end else if (do_read && count_r != CW'(1)) begin
        dout_nxt = mem_r[rd_ptr_inc]; // [R18]
      end
    end
  end

  // Flags are computed from the next count so they change with the count.
  always_comb begin
    flags_nxt.not_empty = (count_nxt != '0); // [R11] [R12]
    flags_nxt.not_full = (count_nxt != FULL_COUNT); // [R13] [R14] [R21]
    flags_nxt.half = (count_nxt >= HALF_COUNT); // [R15] [R16]
    flags_nxt.almost = (count_nxt <= CW'(empty_ofs_nxt)) ||
                       (count_nxt >= (FULL_COUNT - CW'(full_ofs_nxt))); // [R8] [R10]
  end

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
      dout_r <= '0;
      empty_ofs_r <= `OFFSET_DEFAULT; // [R9]
      full_ofs_r <= `OFFSET_DEFAULT; // [R9]
      prog_r <= dual_fifo_pkg::PROG_FIRST;
      flags_r.not_empty <= `RST_NOT_EMPTY; // [R12] [R19]
      flags_r.not_full <= `RST_NOT_FULL; // [R14] [R19]
      flags_r.half <= `RST_HALF; // [R16] [R19]
      flags_r.almost <= `RST_ALMOST; // [R10] [R19]
    end else begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      count_r <= count_nxt;
      dout_r <= dout_nxt;
      empty_ofs_r <= empty_ofs_nxt;
      full_ofs_r <= full_ofs_nxt;
      prog_r <= prog_nxt;
      flags_r <= flags_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------------------
  // Storage words carry no reset; only the pointers and the count decide what is valid.
  always_ff @(posedge clk) begin
    mem_r <= mem_nxt; // [R1]
  end

  assign dout = dout_r;
  assign flags = flags_r;

endmodule : strobed_fifo

module dual_direction_fifo_transceiver #(
  parameter int DEPTH = `FIFO_DEPTH,
  parameter int WIDTH = `FIFO_WIDTH
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Side one data pins.
  input wire logic [WIDTH-1:0] side_one_data_in,
  output logic [WIDTH-1:0] side_one_data_out,
  output logic side_one_data_oe,
  // Side two data pins.
  input wire logic [WIDTH-1:0] side_two_data_in,
  output logic [WIDTH-1:0] side_two_data_out,
  output logic side_two_data_oe,
  // Port controls.
  input wire logic port_a_drive_enable,
  input wire logic port_b_drive_enable,
  input wire logic port_a_source_select,
  input wire logic port_b_source_select,
  // Forward FIFO controls, side one toward side two.
  input wire logic fwd_write_strobe,
  input wire logic fwd_read_strobe,
  input wire logic fwd_clear_n,
  input wire logic fwd_offset_prog_n,
  // Reverse FIFO controls, side two toward side one.
  input wire logic rev_write_strobe,
  input wire logic rev_read_strobe,
  input wire logic rev_clear_n,
  input wire logic rev_offset_prog_n,
  // Forward FIFO status.
  output logic fwd_not_empty_flag,
  output logic fwd_not_full_flag,
  output logic fwd_half_flag,
  output logic fwd_almost_flag,
  // Reverse FIFO status.
  output logic rev_not_empty_flag,
  output logic rev_not_full_flag,
  output logic rev_half_flag,
  output logic rev_almost_flag
);

  // --------------------------------------------------------------------------
  // The two FIFOs
  // --------------------------------------------------------------------------
  logic [WIDTH-1:0] fwd_head;
  logic [WIDTH-1:0] rev_head;
  dual_fifo_pkg::fifo_flags_t fwd_flags;
  dual_fifo_pkg::fifo_flags_t rev_flags;
  logic [WIDTH-1:0] one_out_r;
  logic [WIDTH-1:0] one_out_nxt;
  logic [WIDTH-1:0] two_out_r;
  logic [WIDTH-1:0] two_out_nxt;
  logic one_oe_r;
  logic one_oe_nxt;
  logic two_oe_r;
  logic two_oe_nxt;

  // Each FIFO writes from its own side's input half; a side that the block drives
  // therefore feeds its own output back into the FIFO behind it.
  strobed_fifo #(
    .DEPTH(DEPTH),
    .WIDTH(WIDTH)
  ) u_fwd_fifo (
    .clk(clk),
    .rstn(rstn),
    .clear_n(fwd_clear_n),
    .write_strobe(fwd_write_strobe),
    .read_strobe(fwd_read_strobe),
    .offset_prog_n(fwd_offset_prog_n),
    .din(side_one_data_in),
    .dout(fwd_head),
    .flags(fwd_flags)
  ); // [R1]

  strobed_fifo #(
    .DEPTH(DEPTH),
    .WIDTH(WIDTH)
  ) u_rev_fifo (
    .clk(clk),
    .rstn(rstn),
    .clear_n(rev_clear_n),
    .write_strobe(rev_write_strobe),
    .read_strobe(rev_read_strobe),
    .offset_prog_n(rev_offset_prog_n),
    .din(side_two_data_in),
    .dout(rev_head),
    .flags(rev_flags)
  ); // [R1]

  // --------------------------------------------------------------------------
  // Port source selection and drive
  // --------------------------------------------------------------------------
  // The selected source is registered, so a change of select switches all
  // lines on one edge and no mixed or decoding glitch reaches the pins.
  // The cost is one cycle of latency on live pass-through data.
  // Drive enables are registered too, so data and enable reach the pins on the same edge.
  always_comb begin
    one_out_nxt = port_a_source_select ? rev_head : side_two_data_in; // [R4] [R5]
    two_out_nxt = port_b_source_select ? fwd_head : side_one_data_in; // [R4] [R5]
    one_oe_nxt = port_a_drive_enable; // [R2] [R7]
    two_oe_nxt = port_b_drive_enable; // [R2] [R6]
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      one_out_r <= '0;
      two_out_r <= '0;
      one_oe_r <= 1'b0;
      two_oe_r <= 1'b0;
    end else begin
      one_out_r <= one_out_nxt;
      two_out_r <= two_out_nxt;
      one_oe_r <= one_oe_nxt;
      two_oe_r <= two_oe_nxt;
    end
  end

  assign side_one_data_out = one_out_r;
  assign side_two_data_out = two_out_r;
  assign side_one_data_oe = one_oe_r;
  assign side_two_data_oe = two_oe_r;

  // --------------------------------------------------------------------------
  // Status outputs, each straight from a flag register of its FIFO
  // --------------------------------------------------------------------------
  assign fwd_not_empty_flag = fwd_flags.not_empty;
  assign fwd_not_full_flag = fwd_flags.not_full;
  assign fwd_half_flag = fwd_flags.half;
  assign fwd_almost_flag = fwd_flags.almost;
  assign rev_not_empty_flag = rev_flags.not_empty;
  assign rev_not_full_flag = rev_flags.not_full;
  assign rev_half_flag = rev_flags.half;
  assign rev_almost_flag = rev_flags.almost;

endmodule : dual_direction_fifo_transceiver

// File: dual_fifo_consts.svh
// Constants for the two-direction FIFO transceiver.
// Overview of operation
// [R1] Two 512 x 18 FIFOs, one carrying side one to two, one back.
// [R2] Each side is an 18-bit two-way data port, in or out.
// [R3] Each FIFO's write and read strobes act independently of each other.
// [R4] Source select low passes live opposite-port data, high drives FIFO output.
// [R5] Changing a port's source causes no glitch on its driven lines.
// [R6] Side-two drive enable high drives side two, low leaves it input.
// [R7] Side-one drive enable high drives side one, low leaves it input.
// [R8] Almost flag high when count at most X or at least 512 minus Y.
// [R9] Both offsets default to 128 words unless programmed.
// [R10] After a FIFO clear its almost flag is high.
// [R11] Not-empty flag low while FIFO empty, high while it holds words.
// [R12] After a FIFO clear its not-empty flag is low.
// [R13] Not-full flag low while FIFO full, high otherwise.
// [R14] After a FIFO clear its not-full flag is high.
// [R15] Half flag high at 256 or more words, low at 255 or fewer.
// [R16] After a FIFO clear its half flag is low.
// [R17] A write strobe rising edge stores a word while not full; first shows directly.
// [R18] A read strobe rising edge removes a word while not empty.
// [R19] A low clear input empties the FIFO and forces the reset flag values.
// [R20] Program low after clear: first edge sets both offsets, second only Y.
// [R21] Full at 512 words; writes when full and reads when empty are ignored.
`ifndef DUAL_FIFO_CONSTS_SVH
`define DUAL_FIFO_CONSTS_SVH

// ----------------------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------------------
`define FIFO_DEPTH 512
`define FIFO_WIDTH 18
`define FIFO_HALF_LEVEL 256
`define OFFSET_BITS 8
`define OFFSET_DEFAULT 8'h80

// ----------------------------------------------------------------------------
// Reset values of the outputs
// ----------------------------------------------------------------------------
`define RST_NOT_EMPTY 1'b0
`define RST_NOT_FULL 1'b1
`define RST_HALF 1'b0
`define RST_ALMOST 1'b1

`endif

// File: dual_fifo_pkg.sv
// Types shared by the two-direction FIFO transceiver.
package dual_fifo_pkg;

  // --------------------------------------------------------------------------
  // Status flags of one FIFO, all at their pin polarity.
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic not_empty;
    logic not_full;
    logic half;
    logic almost;
  } fifo_flags_t;

  // --------------------------------------------------------------------------
  // Progress of offset programming after a clear.
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    PROG_FIRST,
    PROG_SECOND,
    PROG_DONE
  } prog_state_t;

endpackage : dual_fifo_pkg

// File: testbench.sv
// Self-checking bench for the two-direction FIFO transceiver.
`timescale 1ns/1ns
module testbench;
  typedef struct packed {logic ga; logic gb; logic sa; logic sb; logic [17:0] val; logic [17:0] exp;} row_t;
  logic clk = 0;
  logic rstn = 0;
  logic ga = 0, gb = 0, sa = 0, sb = 0;
  logic [1:0] ws = 0, rs = 0, cn = 2'h3, pn = 2'h3;
  logic [17:0] av = 0, bv = 0;
  wire [17:0] a_in, b_in, a_out, b_out;
  wire a_oe, b_oe;
  wire [3:0] ffl, rfl;
  int fail_count = 0, checks = 0, i;
  row_t rows [4];
  always #5 clk = ~clk;
  dual_direction_fifo_transceiver dual_direction_fifo_transceiver_i (.clk(clk), .rstn(rstn),
    .side_one_data_in(a_in), .side_one_data_out(a_out), .side_one_data_oe(a_oe),
    .side_two_data_in(b_in), .side_two_data_out(b_out), .side_two_data_oe(b_oe),
    .port_a_drive_enable(ga), .port_b_drive_enable(gb), .port_a_source_select(sa),
    .port_b_source_select(sb), .fwd_write_strobe(ws[0]), .fwd_read_strobe(rs[0]), .fwd_clear_n(cn[0]),
    .fwd_offset_prog_n(pn[0]), .rev_write_strobe(ws[1]), .rev_read_strobe(rs[1]), .rev_clear_n(cn[1]),
    .rev_offset_prog_n(pn[1]), .fwd_not_empty_flag(ffl[3]), .fwd_not_full_flag(ffl[2]),
    .fwd_half_flag(ffl[1]), .fwd_almost_flag(ffl[0]), .rev_not_empty_flag(rfl[3]),
    .rev_not_full_flag(rfl[2]), .rev_half_flag(rfl[1]), .rev_almost_flag(rfl[0]));
  bus_party bus_party_i (.clk(clk), .drive_en(1'b1), .drive_val(av), .pin_out(a_out), .pin_oe(a_oe), .level(a_in));
  bus_party bus_party_j (.clk(clk), .drive_en(1'b1), .drive_val(bv), .pin_out(b_out), .pin_oe(b_oe), .level(b_in));
  task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input int d, input logic [17:0] v);
    @(posedge clk);
    if (d == 1) bv <= v;
    else av <= v;
    ws[d] <= 1'b1;
    @(posedge clk);
    ws[d] <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input int d);
    @(posedge clk);
    rs[d] <= 1'b1;
    @(posedge clk);
    rs[d] <= 1'b0;
    #1;
  endtask : rd
  task automatic clr(input int d);
    @(posedge clk);
    cn[d] <= 1'b0;
    @(posedge clk);
    cn[d] <= 1'b1;
    #1;
  endtask : clr
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up
  initial begin
    #200000;
    fail_count++;
    wrap_up();
  end
  initial begin
    rows[0] = '{1'b0, 1'b1, 1'b0, 1'b0, 18'h0f0f0, 18'h0f0f0};
    rows[1] = '{1'b0, 1'b1, 1'b0, 1'b1, 18'h0f0f0, 18'h2a5c3};
    rows[2] = '{1'b1, 1'b0, 1'b0, 1'b0, 18'h3c3c3, 18'h3c3c3};
    rows[3] = '{1'b1, 1'b0, 1'b1, 1'b0, 18'h3c3c3, 18'h15a3c};
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    #1 chk(ffl, 4'h5);
    chk(rfl, 4'h5);
    $display("reset test done");
    wr(0, 18'h2a5c3);
    chk(ffl[3], 1'b1);
    wr(1, 18'h15a3c);
    chk(rfl[3], 1'b1);
    foreach (rows[k]) begin
      @(posedge clk);
      {ga, gb, sa, sb} <= {rows[k].ga, rows[k].gb, rows[k].sa, rows[k].sb};
      av <= rows[k].val;
      bv <= rows[k].val;
      repeat (2) @(posedge clk);
      #1 chk(rows[k].gb ? b_out : a_out, rows[k].exp);
      chk({a_oe, b_oe}, {rows[k].ga, rows[k].gb});
    end
    @(posedge clk);
    {ga, gb} <= 2'b00;
    rd(1);
    chk(rfl, 4'h5);
    clr(1);
    chk(rfl, 4'h5);
    $display("select test done");
    // Offsets can only be loaded before the first data write, so programming needs a fresh clear.
    clr(0);
    chk(ffl, 4'h5);
    @(posedge clk);
    pn[0] <= 1'b0;
    wr(0, 18'h00002);
    wr(0, 18'h00003);
    chk(ffl[3], 1'b0);
    @(posedge clk);
    pn[0] <= 1'b1;
    for (i = 1; i <= 3; i++) begin
      wr(0, 18'(i));
      chk(ffl[0], i <= 2);
    end
    $display("offset test done");
    clr(0);
    for (i = 1; i <= 512; i++) begin
      wr(0, 18'(i));
      chk(ffl, {1'b1, i != 512, i >= 256, i <= 128 || i >= 384});
    end
    wr(0, 18'h3ffff);
    chk(ffl, 4'hb);
    @(posedge clk);
    gb <= 1'b1;
    sb <= 1'b1;
    for (i = 1; i <= 512; i++) begin
      @(posedge clk);
      #1 chk(b_out, 18'(i));
      rd(0);
    end
    chk(ffl, 4'h5);
    rd(0);
    chk(ffl, 4'h5);
    $display("fill test done");
    wr(0, 18'h00011);
    @(posedge clk);
    rstn <= 1'b0;
    #1 chk(ffl, 4'h5);
    chk({a_oe, b_oe}, 2'b00);
    @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    #1 chk(ffl, 4'h5);
    chk({a_oe, b_oe}, 2'b01);
    chk(b_out, 18'h00000);
    $display("mid-run reset test done");
    wrap_up();
  end
endmodule : testbench

// File: xfer_props.sv
// Concurrent checks on the ports of the two-direction FIFO transceiver.
`timescale 1ns/1ns
module xfer_props #(parameter int WIDTH = 18) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Data sides.
  input wire logic [WIDTH-1:0] side_one_data_in,
  input wire logic [WIDTH-1:0] side_one_data_out,
  input wire logic side_one_data_oe,
  input wire logic [WIDTH-1:0] side_two_data_in,
  input wire logic [WIDTH-1:0] side_two_data_out,
  input wire logic side_two_data_oe,
  // Controls.
  input wire logic port_a_drive_enable,
  input wire logic port_b_drive_enable,
  input wire logic port_a_source_select,
  input wire logic port_b_source_select,
  input wire logic fwd_write_strobe,
  input wire logic fwd_read_strobe,
  input wire logic fwd_clear_n,
  input wire logic fwd_offset_prog_n,
  input wire logic rev_clear_n,
  // Status.
  input wire logic fwd_not_empty_flag,
  input wire logic fwd_not_full_flag,
  input wire logic fwd_half_flag,
  input wire logic fwd_almost_flag,
  input wire logic rev_not_empty_flag,
  input wire logic rev_not_full_flag,
  input wire logic rev_half_flag,
  input wire logic rev_almost_flag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  a_live_to_two: assert property (
    $past(rstn) && !$past(port_b_source_select) |-> side_two_data_out == $past(side_one_data_in))
    else $error("side two live value wrong");
  a_live_to_one: assert property (
    $past(rstn) && !$past(port_a_source_select) |-> side_one_data_out == $past(side_two_data_in))
    else $error("side one live value wrong");
  a_drive_enables: assert property (
    $past(rstn) |-> {side_one_data_oe, side_two_data_oe} == $past({port_a_drive_enable, port_b_drive_enable}))
    else $error("drive enable not followed");
  a_full_flags: assert property (
    !fwd_not_full_flag |-> fwd_not_empty_flag && fwd_half_flag && fwd_almost_flag)
    else $error("flags disagree at full");
  a_empty_flags: assert property (
    !fwd_not_empty_flag |-> fwd_almost_flag && !fwd_half_flag && fwd_not_full_flag)
    else $error("flags disagree at empty");
  a_fwd_clear: assert property (
    !fwd_clear_n |=> {fwd_not_empty_flag, fwd_not_full_flag, fwd_half_flag, fwd_almost_flag} == 4'h5)
    else $error("forward clear flags wrong");
  a_rev_clear: assert property (
    !rev_clear_n |=> {rev_not_empty_flag, rev_not_full_flag, rev_half_flag, rev_almost_flag} == 4'h5)
    else $error("reverse clear flags wrong");
  a_write_stores: assert property (
    $rose(fwd_write_strobe) && fwd_clear_n && fwd_offset_prog_n |=> fwd_not_empty_flag)
    else $error("write did not store");
  a_empty_read: assert property (
    $rose(fwd_read_strobe) && !$rose(fwd_write_strobe) && !fwd_not_empty_flag && fwd_clear_n
    |=> !fwd_not_empty_flag) else $error("read at empty changed flag");
  c_full: cover property (!fwd_not_full_flag);
  c_select: cover property ($rose(port_b_source_select));
  c_rev_clear: cover property (!rev_clear_n);
endmodule : xfer_props
bind dual_direction_fifo_transceiver xfer_props #(.WIDTH(WIDTH)) xfer_props_i (.clk, .rstn,
  .side_one_data_in, .side_one_data_out, .side_one_data_oe, .side_two_data_in, .side_two_data_out,
  .side_two_data_oe, .port_a_drive_enable, .port_b_drive_enable, .port_a_source_select,
  .port_b_source_select, .fwd_write_strobe, .fwd_read_strobe, .fwd_clear_n, .fwd_offset_prog_n,
  .rev_clear_n, .fwd_not_empty_flag, .fwd_not_full_flag, .fwd_half_flag, .fwd_almost_flag,
  .rev_not_empty_flag, .rev_not_full_flag, .rev_half_flag, .rev_almost_flag);
